// ==== hw/bpio_regs.vh ====
// Register map, field layout and reset codes of the bus port block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
// Summary of operation
// - External accesses are 8 or 16 bits wide; the low-byte strobe and address bit 0 mark the width.
// - Strobe and address bit 0 both high only for internal RAM accesses.
// - Misaligned RAM word on a wide bus puts the addressed byte low, the next byte high.
// - Special peripheral mode removes the first sixteen bus registers from the map.
// - Any expanded mode removes both address/data port registers from the map.
// - Expanded mode with emulate bit removes control port registers; peripheral too.
// - High port carries address/data 15..8, otherwise general-purpose I/O; the logic drives only write data 15..8, never bus_addr_i.
// - Low port carries address/data 7..0, otherwise general-purpose I/O; the logic drives only write data 7..0, never bus_addr_i.
// - Direction bit 1 drives the pin; 0 makes it a high-impedance input.
// - Data and direction registers are accessible anytime while mapped.
// - Control port pins carry bus signals or I/O, chosen per pin.
// - One bit enables pullups on control input pins 7 and 3..0, never 6..4; pin 1 always pulled up.
// - Interrupt pins are never outputs and always readable.
// - Alternate function selected overrides the direction bit.
// - Function select resets by mode; normal single-chip gives all I/O.
// - Special single-chip reset enables only the bus clock output.
// - Normal expanded boots externally; read/write needed only for writable memory.
// - Function select readable anytime while mapped; write rights per bit.
// - Normal expanded reset enables only the bus clock pin function.
// - Special expanded enables pipe, clock, read/write, strobe; peripheral hides select.
`ifndef BPIO_REGS_VH
`define BPIO_REGS_VH

// ==========================================================
// Register byte offsets
`define BPIO_OFS_HI_DATA 8'h00
`define BPIO_OFS_LO_DATA 8'h04
`define BPIO_OFS_HI_DIR 8'h08
`define BPIO_OFS_LO_DIR 8'h0c
`define BPIO_OFS_CP_DATA 8'h20
`define BPIO_OFS_CP_DIR 8'h24
`define BPIO_OFS_FSEL 8'h28
`define BPIO_OFS_PULL 8'h2c
`define BPIO_BUS_WIN_END 8'h40

// ==========================================================
// Operating modes
`define BPIO_MODE_SSC 3'h0
`define BPIO_MODE_SEN 3'h1
`define BPIO_MODE_PERI 3'h2
`define BPIO_MODE_SEW 3'h3
`define BPIO_MODE_NSC 3'h4
`define BPIO_MODE_NEN 3'h5
`define BPIO_MODE_NEW 3'h7

// ==========================================================
// Function select fields and control pin numbers
`define BPIO_FS_NO_DBE 7
`define BPIO_FS_PIPE 5
`define BPIO_FS_NO_BUS_CLOCK_OUT 4
`define BPIO_FS_STRB 3
`define BPIO_FS_RDWR 2
`define BPIO_FS_WMASK 8'hbc
`define BPIO_FS_RST_NSC 8'h90
`define BPIO_FS_RST_SSC 8'h80
`define BPIO_FS_RST_NEX 8'h80
`define BPIO_FS_RST_SEX 8'hac
`define BPIO_FS_RST_PERI 8'h90
`define BPIO_CP_DIR_MASK 8'hfc
`define BPIO_PULL_SEL 8'h8f
`define BPIO_PULL_ALWAYS 8'h02
`define BPIO_REG_RST 8'h00

`endif

// ==== hw/bpio_port_ctrl.v ====
// Bus port control: address/data ports, control port and its function select.
// Assumes one clock, synchronous reset and an Avalon-MM master with waitrequest.
`timescale 1ns/1ps
`include "bpio_regs.vh"

module bpio_port_ctrl
(
   input wire core_clk_i,
   input wire rst_i,
   input wire [2:0] mode_i,
   input wire emulate_control_port_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   output reg ext_req_o,
   output reg ext_we_o,
   output reg [7:0] ext_addr_o,
   output reg [7:0] ext_wdata_o,
   input wire [7:0] ext_rdata_i,
   input wire acc_valid_i,
   input wire acc_addr0_i,
   input wire acc_word_i,
   input wire acc_write_i,
   input wire acc_ram_i,
   input wire [15:0] acc_wdata_i,
   input wire bus_wide_i,
   input wire [15:0] bus_addr_i,
   input wire [1:0] pipe_status_i,
   input wire bus_clock_i,
   input wire data_bus_enable_n_i,
   output reg bus_a0_o,
   output reg [1:0] bus_type_o,
   input wire [7:0] high_port_pins_i,
   output wire [7:0] high_port_pins_o,
   output wire [7:0] high_port_pins_oe_o,
   input wire [7:0] low_port_pins_i,
   output wire [7:0] low_port_pins_o,
   output wire [7:0] low_port_pins_oe_o,
   input wire [7:0] control_pins_i,
   output wire [7:0] control_pins_o,
   output wire [7:0] control_pins_oe_o,
   output wire [7:0] control_pullup_o
);

// ==========================================================
// Mode decoding
function is_expanded;
   input [2:0] m;
   begin
      is_expanded = (m == `BPIO_MODE_SEN) || (m == `BPIO_MODE_SEW) ||
                    (m == `BPIO_MODE_NEN) || (m == `BPIO_MODE_NEW);
   end
endfunction

function is_special;
   input [2:0] m;
   begin
      is_special = ~m[2];
   end
endfunction

function is_single;
   input [2:0] m;
   begin
      is_single = (m == `BPIO_MODE_SSC) || (m == `BPIO_MODE_NSC);
   end
endfunction

function [7:0] fsel_reset;
   input [2:0] m;
   begin
      case (m)
         `BPIO_MODE_NSC: fsel_reset = `BPIO_FS_RST_NSC;
         `BPIO_MODE_SSC: fsel_reset = `BPIO_FS_RST_SSC;
         `BPIO_MODE_NEN, `BPIO_MODE_NEW: fsel_reset = `BPIO_FS_RST_NEX;
         `BPIO_MODE_SEN, `BPIO_MODE_SEW: fsel_reset = `BPIO_FS_RST_SEX;
         default: fsel_reset = `BPIO_FS_RST_PERI;
      endcase
   end
endfunction

reg [2:0] mode_reg;
reg [7:0] hi_data_reg;
reg [7:0] hi_dir_reg;
reg [7:0] lo_data_reg;
reg [7:0] lo_dir_reg;
reg [7:0] cp_data_reg;
reg [7:0] cp_dir_reg;
reg [7:0] fsel_reg;
reg [7:0] fsel_wr_reg;
reg pull_reg;
reg done_reg;
reg bus_strobe_n_reg;
reg bus_rw_reg;
reg bus_drive_reg;
reg [15:0] bus_wdata_reg;

wire expanded = is_expanded(mode_reg);
wire special = is_special(mode_reg);
wire peri = (mode_reg == `BPIO_MODE_PERI);
wire single = is_single(mode_reg);

// ==========================================================
// Address decode and map presence
wire req = avs_read_i | avs_write_i;
wire [7:0] a = avs_address_i;
wire in_bus_win = (a < `BPIO_BUS_WIN_END);
wire hit_hi = (a == `BPIO_OFS_HI_DATA) || (a == `BPIO_OFS_HI_DIR);
wire hit_lo = (a == `BPIO_OFS_LO_DATA) || (a == `BPIO_OFS_LO_DIR);
wire hit_cpd = (a == `BPIO_OFS_CP_DATA);
wire hit_cpr = (a == `BPIO_OFS_CP_DIR);
wire hit_fs = (a == `BPIO_OFS_FSEL);
wire hit_pu = (a == `BPIO_OFS_PULL);

wire gone_ab = expanded & (hit_hi | hit_lo);
wire gone_cpd = hit_cpd & ((expanded & emulate_control_port_i) | peri);
wire gone_cpr = hit_cpr & expanded & emulate_control_port_i;
wire gone_win = peri & in_bus_win;
wire removed = gone_ab | gone_cpd | gone_cpr | gone_win;

wire take = req & done_reg;
wire ext_wait = removed & ~ext_req_o;
wire wr_ok = take & avs_write_i & avs_byteenable_i[0] & ~removed;
wire [7:0] wd = avs_writedata_i[7:0];

assign avs_waitrequest_o = req & ~done_reg;

// ==========================================================
// Pin read values
wire [7:0] cp_dir_eff;
wire [7:0] cp_alt;
reg [7:0] rd_val;

always @*
begin
   rd_val = `BPIO_REG_RST;
   case (a)
      `BPIO_OFS_HI_DATA: rd_val = (hi_data_reg & hi_dir_reg) | (high_port_pins_i & ~hi_dir_reg);
      `BPIO_OFS_LO_DATA: rd_val = (lo_data_reg & lo_dir_reg) | (low_port_pins_i & ~lo_dir_reg);
      `BPIO_OFS_HI_DIR: rd_val = hi_dir_reg;
      `BPIO_OFS_LO_DIR: rd_val = lo_dir_reg;
      `BPIO_OFS_CP_DATA: rd_val = (cp_data_reg & cp_dir_eff) | (control_pins_i & ~cp_dir_eff);
      `BPIO_OFS_CP_DIR: rd_val = cp_dir_reg;
      `BPIO_OFS_FSEL: rd_val = fsel_reg;
      `BPIO_OFS_PULL: rd_val = {7'h00, pull_reg};
      default: rd_val = `BPIO_REG_RST;
   endcase
end

// ==========================================================
// Avalon handshake, read data and external cycles
always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      done_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      ext_req_o <= 1'b0;
      ext_we_o <= 1'b0;
      ext_addr_o <= 8'h00;
      ext_wdata_o <= 8'h00;
   end
   else
   begin
      done_reg <= req & ~done_reg & ~ext_wait;
      ext_req_o <= req & ~done_reg & ext_wait;
      if (req & ~done_reg)
      begin
         ext_we_o <= avs_write_i;
         ext_addr_o <= a;
         ext_wdata_o <= wd;
      end
      if (avs_read_i & ~done_reg & ~ext_wait)
         avs_readdata_o <= {24'h000000, removed ? ext_rdata_i : rd_val};
   end
end

// ==========================================================
// Port data and direction registers
always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      mode_reg <= mode_i;
      hi_data_reg <= `BPIO_REG_RST;
      hi_dir_reg <= `BPIO_REG_RST;
      lo_data_reg <= `BPIO_REG_RST;
      lo_dir_reg <= `BPIO_REG_RST;
      cp_data_reg <= `BPIO_REG_RST;
      cp_dir_reg <= `BPIO_REG_RST;
      pull_reg <= 1'b0;
   end
   else if (wr_ok)
   begin
      case (a)
         `BPIO_OFS_HI_DATA: hi_data_reg <= wd;
         `BPIO_OFS_HI_DIR: hi_dir_reg <= wd;
         `BPIO_OFS_LO_DATA: lo_data_reg <= wd;
         `BPIO_OFS_LO_DIR: lo_dir_reg <= wd;
         `BPIO_OFS_CP_DATA: cp_data_reg <= wd;
         `BPIO_OFS_CP_DIR: cp_dir_reg <= wd & `BPIO_CP_DIR_MASK;
         `BPIO_OFS_PULL: pull_reg <= wd[0];
         default: pull_reg <= pull_reg;
      endcase
   end
end

// ==========================================================
// Function select with per-bit write rights
wire [7:0] fs_wmask = `BPIO_FS_WMASK;
wire [7:0] fs_rst = fsel_reset(mode_i);
wire [7:0] fs_hit;
wire [7:0] fs_load;
genvar g;
generate
   for (g = 0; g < 8; g = g + 1)
   begin : g_fsel
      wire lock = (g == `BPIO_FS_NO_BUS_CLOCK_OUT) && expanded;
      wire once_ok = special ? fsel_wr_reg[g] : ~fsel_wr_reg[g];
      assign fs_hit[g] = wr_ok & hit_fs & fs_wmask[g];
      assign fs_load[g] = fs_hit[g] & once_ok & ~lock;
   end
endgenerate

always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      fsel_reg <= fs_rst;
      fsel_wr_reg <= `BPIO_REG_RST;
   end
   else
   begin
      fsel_wr_reg <= fsel_wr_reg | fs_hit;
      fsel_reg <= (fsel_reg & ~fs_load) | (wd & fs_load);
   end
end

// ==========================================================
// External bus access type and data lanes
wire word_eff = acc_word_i & bus_wide_i;
wire word_odd = word_eff & acc_addr0_i;

always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      bus_strobe_n_reg <= 1'b1;
      bus_rw_reg <= 1'b1;
      bus_a0_o <= 1'b0;
      bus_drive_reg <= 1'b0;
      bus_wdata_reg <= 16'h0000;
      bus_type_o <= 2'h0;
   end
   else if (acc_valid_i)
   begin
      bus_strobe_n_reg <= word_eff ? (acc_addr0_i & acc_ram_i) : ~acc_addr0_i;
      bus_rw_reg <= ~acc_write_i;
      bus_a0_o <= acc_addr0_i;
      bus_drive_reg <= acc_write_i;
      bus_type_o <= {word_eff, word_odd & acc_ram_i};
      if (word_odd & acc_ram_i)
         bus_wdata_reg <= {acc_wdata_i[7:0], acc_wdata_i[15:8]};
      else
         bus_wdata_reg <= acc_wdata_i;
   end
   else
   begin
      bus_strobe_n_reg <= 1'b1;
      bus_rw_reg <= 1'b1;
      bus_drive_reg <= 1'b0;
   end
end

// ==========================================================
// Address/data port pins
wire drive_bus = expanded & bus_drive_reg;
assign high_port_pins_o = expanded ? bus_wdata_reg[15:8] : hi_data_reg;
assign high_port_pins_oe_o = expanded ? {8{drive_bus}} : hi_dir_reg;
assign low_port_pins_o = expanded ? bus_wdata_reg[7:0] : lo_data_reg;
assign low_port_pins_oe_o = expanded ? {8{drive_bus}} : lo_dir_reg;

// ==========================================================
// Control port pin functions
wire alt_dbe = expanded & ~fsel_reg[`BPIO_FS_NO_DBE];
wire alt_pipe = ~single & fsel_reg[`BPIO_FS_PIPE];
wire alt_bus_clock_out = ~fsel_reg[`BPIO_FS_NO_BUS_CLOCK_OUT];
wire alt_strb = expanded & fsel_reg[`BPIO_FS_STRB];
wire alt_rw = ~single & fsel_reg[`BPIO_FS_RDWR];

assign cp_alt = {alt_dbe, alt_pipe, alt_pipe, alt_bus_clock_out, alt_strb, alt_rw, 2'b00};
assign cp_dir_eff = cp_dir_reg & `BPIO_CP_DIR_MASK & ~cp_alt;

wire [7:0] alt_val = {data_bus_enable_n_i, pipe_status_i, bus_clock_i,
                      bus_strobe_n_reg, bus_rw_reg, 2'b00};
wire [7:0] alt_oe = {1'b0, alt_pipe, alt_pipe, alt_bus_clock_out, alt_strb, alt_rw, 2'b00};

assign control_pins_o = (alt_val & cp_alt) | (cp_data_reg & ~cp_alt);
assign control_pins_oe_o = alt_oe | cp_dir_eff;
assign control_pullup_o = (`BPIO_PULL_SEL & {8{pull_reg}} & ~control_pins_oe_o) |
                          `BPIO_PULL_ALWAYS;

endmodule // bpio_port_ctrl

// ==== testbench/bpio_port_ctrl_asserts.sv ====
// Port-level checker for the bus port block.
// Assumes it is bound to the port control module from the bench top file.
`timescale 1ns/1ps
module bpio_port_ctrl_chk
(
   input wire core_clk_i,
   input wire rst_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire avs_waitrequest_o,
   input wire ext_req_o,
   input wire ext_we_o,
   input wire acc_valid_i,
   input wire acc_addr0_i,
   input wire acc_word_i,
   input wire acc_ram_i,
   input wire bus_wide_i,
   input wire bus_a0_o,
   input wire [1:0] bus_type_o,
   input wire [7:0] control_pins_oe_o,
   input wire [7:0] control_pullup_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Bus handshake and external path
   chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o || ext_req_o)
      else $error("waitrequest held too long");
   chk_ext_wait: assert property (ext_req_o |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("external access not answered in time");
   chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
   chk_ext_pulse: assert property (ext_req_o |=> !ext_req_o)
      else $error("external request longer than one cycle");
   chk_ext_dir: assert property (ext_req_o |-> (avs_read_i || avs_write_i) && ext_we_o == avs_write_i)
      else $error("external request direction wrong");
   // ==========================================================
   // Pins and access decode
   chk_irq_input: assert property (control_pins_oe_o[1:0] == 2'h0)
      else $error("interrupt pin driven");
   chk_no_pull: assert property ((control_pullup_o & 8'h70) == 8'h00)
      else $error("pullup on pipe or clock pin");
   chk_pull_always: assert property (control_pullup_o[1])
      else $error("interrupt pin pullup missing");
   chk_bus_width: assert property (acc_valid_i |=> bus_a0_o == $past(acc_addr0_i) && bus_type_o[1] == ($past(acc_word_i) && $past(bus_wide_i)))
      else $error("bus width or a0 wrong");
   chk_ram_swap: assert property (acc_valid_i && acc_ram_i && acc_word_i && acc_addr0_i && bus_wide_i |=> bus_type_o[0])
      else $error("ram odd word not swapped");
   chk_noram_swap: assert property (acc_valid_i && !(acc_ram_i && acc_word_i && acc_addr0_i && bus_wide_i) |=> !bus_type_o[0])
      else $error("swap outside ram odd word");
endmodule // bpio_port_ctrl_chk

// ==== testbench/bpio_ext_model.sv ====
// Port replacement model behind the removed register addresses.
// Assumes one-cycle request pulses and data sampled up to a cycle later.
`timescale 1ns/1ps
module bpio_ext_model
(
   input wire core_clk_i,
   input wire ext_req_i,
   input wire ext_we_i,
   input wire [7:0] ext_addr_i,
   input wire [7:0] ext_wdata_i,
   output wire [7:0] ext_rdata_o
);
   reg [7:0] mem_reg [0:255];
   reg hold_reg = 1'b0;
   reg [7:0] junk_reg = 8'h00;
   // ==========================================================
   // Replacement registers
   always @(posedge core_clk_i)
   begin
      hold_reg <= ext_req_i;
      junk_reg <= junk_reg + 8'h35;
      if (ext_req_i && ext_we_i)
      begin
         mem_reg[ext_addr_i] <= ext_wdata_i;
      end
   end
   assign ext_rdata_o = (ext_req_i || hold_reg) ? mem_reg[ext_addr_i] : junk_reg;
endmodule // bpio_ext_model

// ==== testbench/bpio_port_ctrl_tb_top.sv ====
// Bench for the bus port block: mode table, then hand-written cases.
// Assumes the register header on the include path.
`timescale 1ns/1ps
`include "bpio_regs.vh"
module bpio_port_ctrl_tb_top;
   reg core_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [2:0] mode_i = 3'h0;
   reg emulate_control_port_i = 1'b1;
   reg [7:0] avs_address_i = 8'h00;
   reg avs_read_i = 1'b0, avs_write_i = 1'b0, acc_valid_i = 1'b0, acc_addr0_i = 1'b0;
   reg acc_word_i = 1'b0, acc_write_i = 1'b0, acc_ram_i = 1'b0, bus_clock_i = 1'b0;
   reg bus_wide_i = 1'b1;
   reg [31:0] avs_writedata_i = 32'h0;
   reg [3:0] avs_byteenable_i = 4'h0;
   reg [15:0] acc_wdata_i = 16'h0;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, ext_req_o, ext_we_o, bus_a0_o;
   wire [1:0] bus_type_o;
   wire [7:0] ext_addr_o, ext_wdata_o, ext_rdata_i, high_port_pins_o, high_port_pins_oe_o;
   wire [7:0] low_port_pins_o, low_port_pins_oe_o, control_pins_o, control_pins_oe_o;
   wire [7:0] control_pullup_o;
   wire [7:0] high_port_pins_i = (high_port_pins_o & high_port_pins_oe_o) | (~high_port_pins_oe_o & 8'h5a);
   wire [7:0] low_port_pins_i = (low_port_pins_o & low_port_pins_oe_o) | (~low_port_pins_oe_o & 8'ha5);
   wire [7:0] control_pins_i = (control_pins_o & control_pins_oe_o) | (~control_pins_oe_o & 8'h8f);
   integer n_errors = 0, n_checks = 0, n_ext = 0, e, i;
   reg [31:0] q;
   reg [23:0] rows [0:6];
   bpio_port_ctrl bpio_port_ctrl_inst (.core_clk_i, .rst_i, .mode_i, .emulate_control_port_i,
      .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
      .avs_readdata_o, .avs_waitrequest_o, .ext_req_o, .ext_we_o, .ext_addr_o, .ext_wdata_o,
      .ext_rdata_i, .acc_valid_i, .acc_addr0_i, .acc_word_i, .acc_write_i, .acc_ram_i,
      .acc_wdata_i, .bus_wide_i, .bus_addr_i(16'h0), .pipe_status_i(2'h0), .bus_clock_i,
      .data_bus_enable_n_i(1'b1), .bus_a0_o, .bus_type_o, .high_port_pins_i, .high_port_pins_o,
      .high_port_pins_oe_o, .low_port_pins_i, .low_port_pins_o, .low_port_pins_oe_o,
      .control_pins_i, .control_pins_o, .control_pins_oe_o, .control_pullup_o);
   bpio_ext_model bpio_ext_model_inst (.core_clk_i, .ext_req_i(ext_req_o), .ext_we_i(ext_we_o),
      .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));
   initial forever #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i)
   begin
      bus_clock_i <= ~bus_clock_i;
      if (ext_req_o === 1'b1) n_ext = n_ext + 1;
   end
   // ==========================================================
   // Tasks
   task chk(input [31:0] seen, input [31:0] exp, input string what);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task av(input wr, input [7:0] a, input [7:0] d, input [3:0] be);
      integer n;
      begin
         @(posedge core_clk_i);
         avs_address_i <= a;
         avs_write_i <= wr;
         avs_read_i <= !wr;
         avs_writedata_i <= {24'h0, d};
         avs_byteenable_i <= be;
         n = 0;
         @(posedge core_clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 50)
         begin
            @(posedge core_clk_i);
            n = n + 1;
         end
         if (n >= 50) n_errors = n_errors + 1;
         q = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
         @(negedge core_clk_i);
      end
   endtask
   task rst_mode(input [2:0] m);
      begin
         @(posedge core_clk_i);
         rst_i <= 1'b1;
         mode_i <= m;
         repeat (6) @(posedge core_clk_i);
         rst_i <= 1'b0;
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial
   begin
      #200000;
      n_errors = n_errors + 1;
      print_verdict;
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      rows[0] = {5'h0, `BPIO_MODE_SSC, `BPIO_FS_RST_SSC, 8'h0};
      rows[1] = {5'h0, `BPIO_MODE_SEN, `BPIO_FS_RST_SEX, 8'h1};
      rows[2] = {5'h0, `BPIO_MODE_PERI, `BPIO_FS_RST_PERI, 8'h1};
      rows[3] = {5'h0, `BPIO_MODE_SEW, `BPIO_FS_RST_SEX, 8'h1};
      rows[4] = {5'h0, `BPIO_MODE_NSC, `BPIO_FS_RST_NSC, 8'h0};
      rows[5] = {5'h0, `BPIO_MODE_NEN, `BPIO_FS_RST_NEX, 8'h1};
      rows[6] = {5'h0, `BPIO_MODE_NEW, `BPIO_FS_RST_NEX, 8'h1};
      for (i = 0; i < 7; i = i + 1)
      begin
         rst_mode(rows[i][18:16]);
         e = n_ext;
         av(1'b1, `BPIO_OFS_HI_DIR, 8'hf0, 4'h1);
         av(1'b1, `BPIO_OFS_LO_DIR, 8'h0f, 4'h1);
         av(1'b1, `BPIO_OFS_HI_DATA, 8'h5a, 4'h1);
         av(1'b0, `BPIO_OFS_HI_DATA, 8'h00, 4'hf);
         chk(q, 32'h5a, "hi_data");
         av(1'b1, `BPIO_OFS_CP_DATA, 8'ha4, 4'h1);
         chk(n_ext - e, rows[i][0] ? 5 : 0, "ext_count");
         if (!rows[i][0]) chk(high_port_pins_oe_o, 8'hf0, "hi_oe");
         if (!rows[i][0]) chk(low_port_pins_oe_o, 8'h0f, "lo_oe");
         if (rows[i][18:16] != `BPIO_MODE_PERI) av(1'b0, `BPIO_OFS_FSEL, 8'h00, 4'hf);
         if (rows[i][18:16] != `BPIO_MODE_PERI) chk(q, rows[i][15:8], "fsel_rst");
         $display("test mode %0d done", rows[i][18:16]);
      end
      rst_mode(`BPIO_MODE_NSC);
      av(1'b1, `BPIO_OFS_FSEL, 8'h94, 4'h1);
      av(1'b1, `BPIO_OFS_FSEL, 8'h00, 4'h1);
      av(1'b0, `BPIO_OFS_FSEL, 8'h00, 4'hf);
      chk(q, 32'h94, "fsel_once");
      av(1'b1, 8'h30, 8'hff, 4'h1);
      av(1'b0, 8'h30, 8'h00, 4'hf);
      chk(q, 32'h0, "unmapped");
      av(1'b1, `BPIO_OFS_HI_DIR, 8'hff, 4'h0);
      av(1'b0, `BPIO_OFS_HI_DIR, 8'h00, 4'hf);
      chk(q, 32'h0, "no_byteen");
      av(1'b1, `BPIO_OFS_CP_DIR, 8'hff, 4'h1);
      chk(control_pins_oe_o, 8'hfc, "cp_oe_gpio");
      chk(control_pullup_o, 8'h02, "pullup_off");
      av(1'b1, `BPIO_OFS_PULL, 8'h01, 4'h1);
      chk(control_pullup_o, 8'h03, "pullup_on");
      $display("test single chip writes done");
      emulate_control_port_i <= 1'b0;
      rst_mode(`BPIO_MODE_SEW);
      e = n_ext;
      av(1'b1, `BPIO_OFS_CP_DIR, 8'h80, 4'h1);
      chk(control_pins_oe_o, 8'hfc, "cp_oe_alt");
      chk(n_ext - e, 0, "cp_mapped");
      for (i = 0; i < 10; i = i + 1)
      begin
         @(posedge core_clk_i);
         acc_valid_i <= 1'b1;
         acc_word_i <= (i >= 8) ? 1'b1 : i[2];
         acc_write_i <= i[1];
         acc_addr0_i <= (i >= 8) ? 1'b1 : i[0];
         acc_ram_i <= (i != 8);
         acc_wdata_i <= 16'h1234;
         bus_wide_i <= (i != 9);
         @(posedge core_clk_i);
         acc_valid_i <= 1'b0;
         #1;
         if (i < 8) chk({bus_type_o, bus_a0_o, control_pins_o[3:2]},
            {i[2], i[2] & i[0], i[0], i[2] ? i[0] : ~i[0], ~i[1]}, "decode");
         if (i == 8) chk({bus_type_o, control_pins_o[3]}, 3'h4, "noram_word");
         if (i == 9) chk({bus_type_o, control_pins_o[3]}, 3'h0, "narrow_word");
         chk({high_port_pins_o, low_port_pins_o},
            (i < 8 && i[2] && i[0]) ? 16'h3412 : 16'h1234, "lanes");
      end
      $display("test access decode done");
      print_verdict;
   end
endmodule // bpio_port_ctrl_tb_top
bind bpio_port_ctrl bpio_port_ctrl_chk bpio_port_ctrl_chk_inst (.core_clk_i, .rst_i, .avs_read_i,
   .avs_write_i, .avs_waitrequest_o, .ext_req_o, .ext_we_o, .acc_valid_i, .acc_addr0_i,
   .acc_word_i, .acc_ram_i, .bus_wide_i, .bus_a0_o, .bus_type_o, .control_pins_oe_o,
   .control_pullup_o);
